// ===== hw/rxf_pkg.sv
package rxf_pkg;
  // ------------------------------
  // widths
  // ------------------------------
  localparam int ADDR_W = 8;
  localparam int CNT_W  = 32;
  localparam int CH_W   = 3;
  localparam int LEN_W  = 16;
  // ------------------------------
  // register offsets
  // ------------------------------
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] MAXLEN_OFS = 8'h04;
  localparam logic [7:0] SOF_OFS    = 8'h08;
  localparam logic [7:0] MOF_OFS    = 8'h0c;
  localparam logic [7:0] DMA_OFS    = 8'h10;
  // ------------------------------
  // config field positions
  // ------------------------------
  localparam int CA_BIT   = 0;
  localparam int CE_BIT   = 1;
  localparam int CM_BIT   = 2;
  localparam int CS_BIT   = 3;
  localparam int PROM_LSB = 4;
  localparam int CHEN_LSB = 8;
  // ------------------------------
  // reset values and limits
  // ------------------------------
  localparam logic [15:0] CFG_RST    = 16'h0000;
  localparam logic [15:0] MAXLEN_RST = 16'h05ee;
  localparam logic [15:0] MIN_LEN    = 16'h0040;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  // ------------------------------
  // types
  // ------------------------------
  typedef enum logic [2:0] {
    SEL_CFG    = 3'h0,
    SEL_MAXLEN = 3'h1,
    SEL_SOF    = 3'h2,
    SEL_MOF    = 3'h3,
    SEL_DMA    = 3'h4,
    SEL_NONE   = 3'h7
  } rxf_sel_t;

  typedef struct packed {
    logic             hit;
    logic [CH_W-1:0]  hit_ch;
    logic             ctrl;
    logic             crc_err;
    logic             code_err;
    logic             align_err;
    logic [LEN_W-1:0] len;
    logic             fifo_start_loss;
    logic             dma_start_loss;
    logic             fifo_mid_frame_loss;
    logic             dma_mid_loss;
  } rxf_frame_t;

  typedef struct packed {
    logic            accept;
    logic [CH_W-1:0] channel;
    logic            truncate;
    logic            overrun_flag;
    logic            unmatched_frame_flag;
  } rxf_dec_t;
endpackage

// ===== hw/rxf_filter_top.sv
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// RL1: no copy-all drops unmatched; copy-all passes proper
// RL2: copy-short adds undersized frames
// RL3: control frames pass only with copy-control
// RL4: copy-error passes long and errored data
// RL5: error plus short passes fragments too
// RL6: error plus control, no short: no undersized
// RL7: all four set passes every unmatched frame but start overruns
// RL8: matched frames ignore copy-all
// RL9: matched error plus control drops short frames
// RL10: matched all three set passes all but start overruns
// RL11: three counters over four overrun kinds
// RL12: start overrun counts and drops frame
// RL13: mid overrun drops unless copy enables allow
// RL14: matched mid overrun, no error: drop, count
// RL15: unmatched mid overrun keeps data, two flags
// RL16: matched mid overrun keeps data, overrun flag
// RL17: over-length frame truncates, never overrun
// RL18: match needs an enabled channel
// RL19: proper is 64 to max, error free
// RL20: short/long split by error into four classes
// RL21: config field picks promiscuous channel
// RL22: each counter steps at most once per frame
module rxf_filter_top (
  // clock and reset
  input  logic                     core_clk_in,
  input  logic                     rstn_in,
  // frame summary from receive path
  input  logic                     frame_valid_in,
  input  rxf_pkg::rxf_frame_t      frame_in,
  // decision toward receive dma
  output logic                     dec_valid_out,
  output rxf_pkg::rxf_dec_t        dec_out,
  // axi4-lite write
  input  logic [rxf_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input  logic                     s_axi_awvalid_in,
  output logic                     s_axi_awready_out,
  input  logic [31:0]              s_axi_wdata_in,
  input  logic [3:0]               s_axi_wstrb_in,
  input  logic                     s_axi_wvalid_in,
  output logic                     s_axi_wready_out,
  output logic [1:0]               s_axi_bresp_out,
  output logic                     s_axi_bvalid_out,
  input  logic                     s_axi_bready_in,
  // axi4-lite read
  input  logic [rxf_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input  logic                     s_axi_arvalid_in,
  output logic                     s_axi_arready_out,
  output logic [31:0]              s_axi_rdata_out,
  output logic [1:0]               s_axi_rresp_out,
  output logic                     s_axi_rvalid_out,
  input  logic                     s_axi_rready_in
);
  import rxf_pkg::*;

  typedef struct packed {
    logic [15:0]       cfg;
    logic [15:0]       maxlen;
    logic [CNT_W-1:0]  sof_cnt;
    logic [CNT_W-1:0]  mof_cnt;
    logic [CNT_W-1:0]  dma_cnt;
    logic              dec_v;
    rxf_dec_t          dec;
    logic              awrdy;
    logic              wrdy;
    logic              awgot;
    logic              wgot;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } rxf_state_t;

  rxf_state_t s;
  rxf_state_t next_s;
  logic [1:0] rst_sync;
  logic       rst_n;

  // ------------------------------
  // reset release
  // ------------------------------
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ------------------------------
  // helpers
  // ------------------------------
  function automatic rxf_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    unique case ({a[ADDR_W-1:2], 2'h0})
      CFG_OFS:    reg_sel = SEL_CFG;
      MAXLEN_OFS: reg_sel = SEL_MAXLEN;
      SOF_OFS:    reg_sel = SEL_SOF;
      MOF_OFS:    reg_sel = SEL_MOF;
      DMA_OFS:    reg_sel = SEL_DMA;
      default:    reg_sel = SEL_NONE;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  b);
    merge16 = o;
    for (int i = 0; i < 2; i++) begin
      if (b[i]) begin
        merge16[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction

  // ------------------------------
  // frame classification
  // ------------------------------
  logic ca, ce, cm, cs;
  logic f_err, f_short, f_long, f_match;
  logic f_sof, f_mof, f_pass, f_take, f_dma;
  logic [CH_W-1:0] prom;

  assign ca   = s.cfg[CA_BIT];
  assign ce   = s.cfg[CE_BIT];
  assign cm   = s.cfg[CM_BIT];
  assign cs   = s.cfg[CS_BIT];
  assign prom = s.cfg[PROM_LSB +: CH_W]; // RL21
  assign f_err = frame_in.crc_err | frame_in.code_err | frame_in.align_err; // RL20
  assign f_short = frame_in.len < MIN_LEN; // RL19
  assign f_long  = frame_in.len > s.maxlen; // RL19
  // disabled channel means unmatched
  assign f_match = frame_in.hit & s.cfg[CHEN_LSB + int'(frame_in.hit_ch)]; // RL18
  assign f_sof = frame_in.fifo_start_loss | frame_in.dma_start_loss; // RL11
  // a truncated frame is long, so its overrun is not counted
  assign f_mof = (frame_in.fifo_mid_frame_loss | frame_in.dma_mid_loss)
                 & ~f_long & ~f_sof; // RL17
  assign f_dma = frame_in.dma_start_loss | (frame_in.dma_mid_loss & f_mof); // RL11
  // short needs copy-short, errors and long need copy-error
  assign f_pass = f_short ? (cs & (~f_err | ce)) : (~(f_err | f_long) | ce); // RL2 RL4 RL5 RL6
  assign f_take = ~f_sof & (f_match | ca) & (~frame_in.ctrl | cm)
                  & (f_mof ? ce : f_pass); // RL1 RL3 RL7 RL8 RL9 RL10 RL12 RL13 RL14

  // ------------------------------
  // next state
  // ------------------------------
  always_comb begin
    next_s = s;
    next_s.dec_v = 1'b0;
    if (frame_valid_in) begin
      next_s.dec_v = 1'b1;
      next_s.dec.accept = f_take;
      next_s.dec.channel = f_match ? frame_in.hit_ch : prom; // RL8 RL21
      next_s.dec.truncate = f_long & f_take; // RL17
      next_s.dec.overrun_flag = f_mof & f_take; // RL15 RL16
      next_s.dec.unmatched_frame_flag = ~f_match & f_take; // RL15
      next_s.sof_cnt = s.sof_cnt + CNT_W'(f_sof); // RL12 RL22
      next_s.mof_cnt = s.mof_cnt + CNT_W'(f_mof); // RL13 RL22
      next_s.dma_cnt = s.dma_cnt + CNT_W'(f_dma); // RL11 RL22
    end
    if (s_axi_awvalid_in && s.awrdy) begin
      next_s.awgot = 1'b1;
      next_s.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s.wrdy) begin
      next_s.wgot = 1'b1;
      next_s.wdata = s_axi_wdata_in;
      next_s.wstrb = s_axi_wstrb_in;
    end
    if (s.bvalid && s_axi_bready_in) begin
      next_s.bvalid = 1'b0;
    end
    // counters are read only; writes to them are ignored
    if (s.awgot && s.wgot && !s.bvalid) begin
      next_s.awgot = 1'b0;
      next_s.wgot = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (reg_sel(s.awaddr))
        SEL_CFG:    next_s.cfg = merge16(s.cfg, s.wdata, s.wstrb);
        SEL_MAXLEN: next_s.maxlen = merge16(s.maxlen, s.wdata, s.wstrb);
        SEL_SOF, SEL_MOF, SEL_DMA: next_s.bresp = RESP_OKAY;
        default:    next_s.bresp = RESP_SLV;
      endcase
    end
    next_s.awrdy = !next_s.awgot && !next_s.bvalid;
    next_s.wrdy = !next_s.wgot && !next_s.bvalid;
    if (s.rvalid && s_axi_rready_in) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s.arrdy) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      unique case (reg_sel(s_axi_araddr_in))
        SEL_CFG:    next_s.rdata = {16'h0000, s.cfg};
        SEL_MAXLEN: next_s.rdata = {16'h0000, s.maxlen};
        SEL_SOF:    next_s.rdata = s.sof_cnt;
        SEL_MOF:    next_s.rdata = s.mof_cnt;
        SEL_DMA:    next_s.rdata = s.dma_cnt;
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLV;
        end
      endcase
    end
    next_s.arrdy = !next_s.rvalid;
  end

  // ------------------------------
  // state register
  // ------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.cfg <= CFG_RST;
      s.maxlen <= MAXLEN_RST;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------
  // outputs
  // ------------------------------
  assign dec_valid_out     = s.dec_v;
  assign dec_out           = s.dec;
  assign s_axi_awready_out = s.awrdy;
  assign s_axi_wready_out  = s.wrdy;
  assign s_axi_bvalid_out  = s.bvalid;
  assign s_axi_bresp_out   = s.bresp;
  assign s_axi_arready_out = s.arrdy;
  assign s_axi_rvalid_out  = s.rvalid;
  assign s_axi_rresp_out   = s.rresp;
  assign s_axi_rdata_out   = s.rdata;

  // ------------------------------
  // checks
  // ------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  AST_NO_COPY_ALL: assert property ( // RL1
    frame_valid_in && !f_match && !ca |=> dec_valid_out && !dec_out.accept)
    else $error("unmatched frame passed without copy-all");
  AST_UNDERSIZED: assert property ( // RL2
    frame_valid_in && f_short && !f_err && !frame_in.ctrl && !f_sof && !f_mof
    |=> dec_out.accept == $past(cs && (f_match || ca)))
    else $error("undersized frame treatment wrong");
  AST_CONTROL: assert property ( // RL3
    frame_valid_in && frame_in.ctrl && !cm |=> !dec_out.accept)
    else $error("control frame passed with copy-control clear");
  AST_ERR_NEEDS_CE: assert property ( // RL4
    frame_valid_in && (f_err || f_long) && !ce |=> !dec_out.accept)
    else $error("errored frame passed with copy-error clear");
  // a short frame that overruns mid-frame follows copy-error instead
  AST_FRAGMENT: assert property ( // RL5
    frame_valid_in && f_short && f_err && !cs && !f_mof
    |=> !dec_out.accept)
    else $error("fragment passed with copy-short clear");
  AST_ALL_SET: assert property ( // RL7
    frame_valid_in && (&s.cfg[CS_BIT:CA_BIT]) && !f_sof
    |=> dec_out.accept && dec_out.unmatched_frame_flag == !$past(f_match))
    else $error("frame lost with all copy enables set");
  AST_CHANNEL: assert property ( // RL21
    frame_valid_in && !f_match |=> dec_out.channel == $past(prom))
    else $error("unmatched frame on wrong channel");
  AST_DISABLED_CH: assert property ( // RL18
    frame_valid_in && frame_in.hit && !s.cfg[CHEN_LSB + int'(frame_in.hit_ch)]
    |=> !dec_out.accept || dec_out.unmatched_frame_flag)
    else $error("disabled channel treated as match");
  AST_SOF_DROP: assert property ( // RL12
    frame_valid_in && f_sof
    |=> !dec_out.accept && s.sof_cnt == $past(s.sof_cnt) + 1'b1)
    else $error("start overrun not dropped and counted");
  AST_MOF_KEEP: assert property ( // RL16
    frame_valid_in && f_mof && ce && f_match && (!frame_in.ctrl || cm)
    |=> dec_out.accept && dec_out.overrun_flag && !dec_out.unmatched_frame_flag
        && s.mof_cnt == $past(s.mof_cnt) + 1'b1)
    else $error("matched mid overrun mishandled");
  AST_LONG_TRUNC: assert property ( // RL17
    frame_valid_in && f_long |=> !dec_out.overrun_flag
    && s.mof_cnt == $past(s.mof_cnt) && dec_out.truncate == dec_out.accept)
    else $error("long frame counted as overrun");
  AST_DMA_ONCE: assert property ( // RL22
    frame_valid_in && frame_in.dma_start_loss && frame_in.dma_mid_loss
    |=> s.dma_cnt == $past(s.dma_cnt) + 1'b1)
    else $error("dma counter stepped more than once");
  AST_BRESP_TIME: assert property (
    s_axi_awvalid_in && s.awrdy && s_axi_wvalid_in && s.wrdy |=> ##1 s_axi_bvalid_out)
    else $error("write response late");

  COV_PROM_PASS: cover property (
    dec_valid_out && dec_out.accept && dec_out.unmatched_frame_flag);
  COV_MOF_KEEP: cover property (dec_valid_out && dec_out.overrun_flag);
  COV_TRUNC: cover property (dec_valid_out && dec_out.truncate);
  COV_SOF: cover property (frame_valid_in && f_sof);
endmodule // rxf_filter_top

// ===== testbench/rxf_frame_src.sv
`timescale 1ns/1ps
module rxf_frame_src
  import rxf_pkg::*;
(
  // clock
  input  logic                core_clk_in,
  // frame summary toward the filter
  output logic                frame_valid_out,
  output rxf_pkg::rxf_frame_t frame_out
);
  initial begin
    frame_valid_out = 1'b0;
    frame_out       = '0;
  end
  // ------------------------------
  // one summary pulse per frame
  // ------------------------------
  task automatic send(input rxf_frame_t f);
    @(posedge core_clk_in);
    frame_valid_out <= 1'b1;
    frame_out       <= f;
    @(posedge core_clk_in);
    frame_valid_out <= 1'b0;
    // stale summary not held, so a late sample shows up
    frame_out       <= ~f;
  endtask
endmodule // rxf_frame_src

// ===== testbench/rxf_filter_top_tb.sv
`timescale 1ns/1ps
module rxf_filter_top_tb;
  import rxf_pkg::*;
  // ------------------------------
  // signals
  // ------------------------------
  logic        clk, rstn, fv, dv, awv, awr, wv, wr, bv, brdy, arv, arr, rv, rrdy;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, d;
  logic [3:0]  ws;
  logic [1:0]  br, rr, r;
  logic [15:0] cfg, maxlen;
  rxf_frame_t  fr;
  rxf_dec_t    dec;
  int          err_count, n_compared, sofc, mofc, dmac;

  rxf_filter_top dut (.core_clk_in(clk), .rstn_in(rstn), .frame_valid_in(fv), .frame_in(fr),
    .dec_valid_out(dv), .dec_out(dec), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(brdy), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy));
  rxf_frame_src src (.core_clk_in(clk), .frame_valid_out(fv), .frame_out(fr));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ------------------------------
  // compare and close
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n > 50) begin
      err_count++;
      $display("[ERR] bus_answer expected 1 seen 0");
      finish_test();
    end
  endtask
  // ------------------------------
  // axi4-lite master
  // ------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    awa  <= a;
    wd   <= v;
    awv  <= 1'b1;
    wv   <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      tmo(n);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    rs = br;
    brdy <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    ara  <= a;
    arv  <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      tmo(n);
      if (arr) arv <= 1'b0;
    end while (!rv);
    v = rd;
    rs = rr;
    rrdy <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] rs);
    axi_rd(a, d, r);
    chk(nm, d, v);
    chk("read_resp", 32'(r), 32'(rs));
  endtask
  // ------------------------------
  // frame expectation
  // ------------------------------
  function automatic rxf_dec_t exp_dec(input rxf_frame_t f);
    rxf_dec_t e;
    logic     m, sh, lg, er, sof, mof, pass;
    m    = f.hit && cfg[CHEN_LSB + f.hit_ch];
    sh   = f.len < MIN_LEN;
    lg   = f.len > maxlen;
    er   = f.crc_err | f.code_err | f.align_err;
    sof  = f.fifo_start_loss | f.dma_start_loss;
    mof  = (f.fifo_mid_frame_loss | f.dma_mid_loss) && !lg && !sof;
    pass = sh ? cfg[CS_BIT] && (!er || cfg[CE_BIT]) : (!(er || lg) || cfg[CE_BIT]);
    e.accept  = !sof && (m || cfg[CA_BIT]) && (!f.ctrl || cfg[CM_BIT]) && (mof ? cfg[CE_BIT] : pass);
    e.channel = m ? f.hit_ch : cfg[PROM_LSB +: CH_W];
    e.truncate = lg && e.accept;
    e.overrun_flag = mof && e.accept;
    e.unmatched_frame_flag = !m && e.accept;
    return e;
  endfunction
  function automatic rxf_frame_t rnd_frame();
    rxf_frame_t f;
    f = rxf_frame_t'(28'($urandom));
    if ($urandom % 2) {f.crc_err, f.code_err, f.align_err} = 3'h0;
    if ($urandom % 3) {f.fifo_start_loss, f.dma_start_loss, f.fifo_mid_frame_loss,
                       f.dma_mid_loss} = 4'h0;
    case ($urandom % 6)
      0: f.len = MIN_LEN - 16'h0001;
      1: f.len = MIN_LEN;
      2: f.len = maxlen;
      3: f.len = maxlen + 16'h0001;
      default: f.len = 16'($urandom % 2000);
    endcase
    return f;
  endfunction
  task automatic frame(input rxf_frame_t f);
    // dropped frames still count their overruns
    sofc += int'(f.fifo_start_loss | f.dma_start_loss);
    mofc += int'((f.fifo_mid_frame_loss | f.dma_mid_loss) && f.len <= maxlen &&
                 !(f.fifo_start_loss | f.dma_start_loss));
    dmac += int'(f.dma_start_loss | (f.dma_mid_loss && f.len <= maxlen &&
                 !(f.fifo_start_loss | f.dma_start_loss)));
    src.send(f);
    #1;
    chk("dec_valid", 32'(dv), 32'h1);
    chk("dec", 32'(dec), 32'(exp_dec(f)));
    // valid is a one-cycle pulse, the decision itself stays put
    @(posedge clk);
    #1;
    chk("dec_pulse", 32'(dv), 32'h0);
    chk("dec_hold", 32'(dec), 32'(exp_dec(f)));
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    {rstn, awv, wv, brdy, arv, rrdy, awa, ara, wd} = '0;
    ws = 4'hf;
    {err_count, n_compared, sofc, mofc, dmac} = '0;
    void'($urandom(32'hb05a));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rchk("cfg", CFG_OFS, 32'(CFG_RST), RESP_OKAY);
    rchk("maxlen", MAXLEN_OFS, 32'(MAXLEN_RST), RESP_OKAY);
    axi_wr(SOF_OFS, 32'h5, r);
    chk("cnt_wr_resp", 32'(r), 32'(RESP_OKAY));
    rchk("sof_ro", SOF_OFS, 32'h0, RESP_OKAY);
    axi_wr(8'h14, 32'h1, r);
    chk("unmapped_wr", 32'(r), 32'(RESP_SLV));
    rchk("unmapped_rd", 8'h14, 32'h0, RESP_SLV);
    $display("test registers done");
    cfg = CFG_RST;
    for (int m = 0; m < 2; m++) begin
      // short max length of 100 puts most random lengths above the oversize edge
      maxlen = m ? 16'h0064 : MAXLEN_RST;
      axi_wr(MAXLEN_OFS, {16'h0, maxlen}, r);
      for (int en = 0; en < 16; en++) begin
        cfg = {8'($urandom), 1'b0, 3'($urandom), 4'(en)};
        axi_wr(CFG_OFS, {16'h0, cfg}, r);
        repeat (40) frame(rnd_frame());
      end
      $display("test sweep %0d done", m);
    end
    rchk("sof_cnt", SOF_OFS, 32'(sofc), RESP_OKAY);
    rchk("mof_cnt", MOF_OFS, 32'(mofc), RESP_OKAY);
    rchk("dma_cnt", DMA_OFS, 32'(dmac), RESP_OKAY);
    $display("test counters done");
    // second reset in mid-run: counters and config back to reset values
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rchk("sof_rst", SOF_OFS, 32'h0, RESP_OKAY);
    rchk("mof_rst", MOF_OFS, 32'h0, RESP_OKAY);
    rchk("cfg_rst", CFG_OFS, 32'(CFG_RST), RESP_OKAY);
    rchk("maxlen_rst", MAXLEN_OFS, 32'(MAXLEN_RST), RESP_OKAY);
    $display("test reset done");
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("[ERR] run_end expected 1 seen 0");
    finish_test();
  end
endmodule // rxf_filter_top_tb
